//--- common/mrs_consts.svh
// offsets, field positions, reset values and timing counts of the mode bank
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define MRS_OFS_MR0      8'h00
`define MRS_OFS_STATUS   8'h1c
`define MRS_OFS_FLAGS    8'h20
`define MRS_OFS_CTRL     8'h24
`define MRS_NUM_MR       7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MRS_CTRL_CHECK   0
`define MRS_CTRL_STRICT  1
`define MRS_FLG_IDLE     0
`define MRS_FLG_EARLY    1
`define MRS_FLG_CMD      2
`define MRS_FLG_ODT      3
`define MRS_NUM_FLG      4
`define MRS_RTT_HI       10
`define MRS_RTT_LO       8
`define MRS_GEAR_BIT     3
`define MRS_PDA_BIT      4
`define MRS_MPS_BIT      1
`define MRS_CAL_HI       8
`define MRS_CAL_LO       6
`define MRS_PAR_HI       2
`define MRS_PAR_LO       0
`define MRS_VREF_HI      7
`define MRS_VREF_LO      0

// ----------------------------------------------------------------
// reset values: gear-down half rate (0), every latency mode off
// ----------------------------------------------------------------
`define MRS_MR_RST       14'h0000
`define MRS_CTRL_RST     2'h1
`define MRS_RESP_OK      2'h0
`define MRS_RESP_SLVERR  2'h2

// ----------------------------------------------------------------
// timing, nanoseconds and clock cycles (least times round up)
// ----------------------------------------------------------------
`define MRS_CLK_NS       100
`define MRS_T_MRD_NS     800
`define MRS_T_MOD_NS     2400
`define MRS_T_UPD_NS     4000
`define MRS_CYC(ns)      (((ns) + `MRS_CLK_NS - 1) / `MRS_CLK_NS)

`endif

//--- common/mrs_pkg.sv
// types shared by the mode register bank
package mrs_pkg;

	// one command slot from the controller, same clock as the bank
	typedef struct packed {
		logic        mrs;   // mode register set registered
		logic        other; // any other command except deselect
		logic [2:0]  sel;   // target mode register
		logic [13:0] addr;  // full address payload
		logic        odt;   // termination pin level
		logic        cke;   // clock enable level
		logic        idle;  // all banks precharged, bursts done
	} mrs_cmd_t;

	// write side of the register slave
	typedef enum logic [0:0] {
		MRS_W_IDLE = 1'b0,
		MRS_W_RESP = 1'b1
	} mrs_wst_t;

endpackage

//--- rtl/mrs_timer.sv
// down counter that holds a busy level for a loaded number of cycles
`timescale 1ns/1ns
`include "mrs_consts.svh"

module mrs_timer #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// state
	output logic              busy_q
);

	logic [W-1:0] cnt_q; // cycles still to wait

	// ----------------------------------------------------------------
	// counter: a load restarts the window, never extends a stale one
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end else if (load) begin
			cnt_q  <= load_val;
			busy_q <= (load_val != '0);
		end else begin
			cnt_q  <= (cnt_q != '0) ? cnt_q - 1'b1 : '0;
			busy_q <= (cnt_q > 1);
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	busy_count_a: assert property (busy_q == (cnt_q != '0))
		else $error("timer busy level disagrees with count");

endmodule

//--- rtl/mrs_top.sv
// mode register bank with command spacing checks and an axi4-lite slave
//
// Function
// - seven mode registers, each written by mrs
// - mrs leaves array contents untouched
// - termination off both sides: odt free
// - two mrs commands spaced by tmrd
// - parity, latency, addressability, vref also exempt
// - reset defaults: half rate, modes disabled
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "mrs_consts.svh"

module mrs_top
	import mrs_pkg::*;
#(
	parameter int TMRD_CYC = `MRS_CYC(`MRS_T_MRD_NS),
	parameter int TMOD_CYC = `MRS_CYC(`MRS_T_MOD_NS),
	parameter int TUPD_CYC = `MRS_CYC(`MRS_T_UPD_NS)
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// command slot from the controller
	input  wire mrs_cmd_t    cmd,
	// mode state seen by the rest of the device
	output logic [13:0]      mr_out_q [`MRS_NUM_MR],
	output logic             mrd_busy_q,
	output logic             mod_busy_q,
	// axi4-lite write address
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	// axi4-lite write data
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// axi4-lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [13:0]              mr_q [`MRS_NUM_MR]; // mode registers
	logic [1:0]               ctrl_q;   // check enable, strict
	logic [`MRS_NUM_FLG-1:0]  flag_q;   // sticky violations
	logic [`MRS_NUM_FLG-1:0]  flag_set; // events this cycle
	logic [`MRS_NUM_FLG-1:0]  flag_clr; // software clear this cycle
	logic                     odt_prev_q; // odt one cycle earlier
	logic                     rtt_on_q; // termination kept off window
	logic                     upd_busy; // long update pending
	logic                     accept;   // mrs taken into a register
	logic                     exc;      // mrs changes exempt fields
	logic                     rtt_new;  // termination on after mrs
	logic                     mrd_blk;  // spacing not yet met
	mrs_wst_t                 wst_q;    // write side state
	logic                     aw_have_q, w_have_q;
	logic [7:0]               awaddr_q;
	logic [31:0]              wdata_q;
	logic [3:0]               wstrb_q;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// termination is on when its field in register 1 is nonzero
	function automatic logic rtt_any(input logic [13:0] v);
		return v[`MRS_RTT_HI:`MRS_RTT_LO] != 3'h0;
	endfunction

	// register index of a mapped mode register address, else 7
	function automatic logic [2:0] mr_idx(input logic [7:0] a);
		return (a[1:0] == 2'h0 && a < `MRS_OFS_STATUS) ?
			a[4:2] : 3'h7;
	endfunction

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	assign mrd_blk = mrd_busy_q | upd_busy;
	// strict mode drops commands that break idle or spacing; the
	// array has no path here, so no command can disturb it
	assign accept = cmd.mrs && cmd.sel < 3'(`MRS_NUM_MR) &&
		!(ctrl_q[`MRS_CTRL_STRICT] &&
		(mrd_blk || !cmd.idle || !cmd.cke));
	assign rtt_new = (cmd.sel == 3'h1) ? rtt_any(cmd.addr)
		: rtt_any(mr_q[1]);

	// settings that change how inputs are sampled need longer
	always_comb begin
		case (cmd.sel)
		3'h3:    exc = (cmd.addr[`MRS_GEAR_BIT] != mr_q[3][`MRS_GEAR_BIT])
			|| (cmd.addr[`MRS_PDA_BIT] != mr_q[3][`MRS_PDA_BIT]);
		3'h4:    exc = cmd.addr[`MRS_CAL_HI:`MRS_CAL_LO] !=
			mr_q[4][`MRS_CAL_HI:`MRS_CAL_LO];
		3'h5:    exc = cmd.addr[`MRS_PAR_HI:`MRS_PAR_LO] !=
			mr_q[5][`MRS_PAR_HI:`MRS_PAR_LO];
		3'h6:    exc = cmd.addr[`MRS_VREF_HI:`MRS_VREF_LO] !=
			mr_q[6][`MRS_VREF_HI:`MRS_VREF_LO];
		default: exc = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// mode registers: whole word replaced, defaults at reset
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `MRS_NUM_MR; i++) begin
				mr_q[i]     <= `MRS_MR_RST;
				mr_out_q[i] <= `MRS_MR_RST;
			end
		end else if (accept) begin
			mr_q[cmd.sel]     <= cmd.addr;
			mr_out_q[cmd.sel] <= cmd.addr;
		end
	end

	// ----------------------------------------------------------------
	// spacing timers
	// ----------------------------------------------------------------
	mrs_timer #(.W(12)) u_mrd (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (accept),
		.load_val (12'(TMRD_CYC - 1)),
		.busy_q   (mrd_busy_q)
	);
	mrs_timer #(.W(12)) u_mod (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (accept),
		.load_val (12'(TMOD_CYC - 1)),
		.busy_q   (mod_busy_q)
	);
	mrs_timer #(.W(12)) u_upd (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (accept && exc),
		.load_val (12'(TUPD_CYC - 1)),
		.busy_q   (upd_busy)
	);

	// ----------------------------------------------------------------
	// termination window: set by an mrs with termination on either
	// side, held until tmod runs out
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rtt_on_q   <= 1'b0;
			odt_prev_q <= 1'b0;
		end else begin
			odt_prev_q <= cmd.odt;
			if (accept)
				rtt_on_q <= rtt_any(mr_q[1]) || rtt_new;
			else if (!mod_busy_q)
				rtt_on_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// violation events; only the controller can break these
	// ----------------------------------------------------------------
	always_comb begin
		flag_set = '0;
		if (ctrl_q[`MRS_CTRL_CHECK]) begin
			flag_set[`MRS_FLG_IDLE]  = cmd.mrs &&
				(!cmd.idle || !cmd.cke);
			flag_set[`MRS_FLG_EARLY] = cmd.mrs && mrd_blk;
			flag_set[`MRS_FLG_CMD]   = cmd.other && mod_busy_q;
			flag_set[`MRS_FLG_ODT]   = (accept &&
				(rtt_any(mr_q[1]) || rtt_new) &&
				(cmd.odt || odt_prev_q)) ||
				(rtt_on_q && mod_busy_q && cmd.odt);
		end
	end

	// ----------------------------------------------------------------
	// sticky flags: a set in the clearing cycle survives
	// ----------------------------------------------------------------
	assign flag_clr = (wst_q == MRS_W_IDLE && aw_have_q && w_have_q &&
		awaddr_q == `MRS_OFS_FLAGS && wstrb_q[0]) ?
		wdata_q[`MRS_NUM_FLG-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			flag_q <= '0;
		else
			flag_q <= (flag_q & ~flag_clr) | flag_set;
	end

	// ----------------------------------------------------------------
	// write side: address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q     <= MRS_W_IDLE;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= `MRS_RESP_OK;
			ctrl_q    <= `MRS_CTRL_RST;
		end else begin
			case (wst_q)
			MRS_W_IDLE: begin
				if (awvalid && awready) begin
					awaddr_q  <= awaddr;
					aw_have_q <= 1'b1;
					awready   <= 1'b0;
				end
				if (wvalid && wready) begin
					wdata_q  <= wdata;
					wstrb_q  <= wstrb;
					w_have_q <= 1'b1;
					wready   <= 1'b0;
				end
				if (aw_have_q && w_have_q) begin
					// mode registers are for the command bus only
					if (awaddr_q == `MRS_OFS_CTRL) begin
						if (wstrb_q[0])
							ctrl_q <= wdata_q[1:0];
						bresp <= `MRS_RESP_OK;
					end else if (awaddr_q == `MRS_OFS_FLAGS)
						bresp <= `MRS_RESP_OK;
					else
						bresp <= `MRS_RESP_SLVERR;
					bvalid    <= 1'b1;
					aw_have_q <= 1'b0;
					w_have_q  <= 1'b0;
					wst_q     <= MRS_W_RESP;
				end
			end
			MRS_W_RESP: begin
				if (bready) begin
					bvalid  <= 1'b0;
					awready <= 1'b1;
					wready  <= 1'b1;
					wst_q   <= MRS_W_IDLE;
				end
			end
			default: wst_q <= MRS_W_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read side: one cycle from address to data
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `MRS_RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `MRS_RESP_OK;
			rdata   <= 32'h0000_0000;
			if (mr_idx(araddr) != 3'h7)
				rdata <= {18'h00000, mr_q[mr_idx(araddr)]};
			else if (araddr == `MRS_OFS_STATUS)
				rdata <= {29'h0, rtt_on_q, mod_busy_q, mrd_blk};
			else if (araddr == `MRS_OFS_FLAGS)
				rdata <= {28'h0, flag_q};
			else if (araddr == `MRS_OFS_CTRL)
				rdata <= {30'h0, ctrl_q};
			else
				rresp <= `MRS_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	full_rewrite_a: assert property (accept |=>
		mr_q[$past(cmd.sel)] == $past(cmd.addr))
		else $error("mode register not replaced whole");
	reset_default_a: assert property ($rose(aresetn) |->
		mr_q[3] == 14'h0000 && mr_q[4] == 14'h0000 &&
		mr_q[5] == 14'h0000)
		else $error("mode defaults wrong after reset");
	// cycles since the last accepted mrs, saturating; kept apart from
	// the spacing timer so a broken timer cannot hide behind itself
	logic [11:0] gap_q;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			gap_q <= '1;
		else if (accept)
			gap_q <= 12'h000;
		else if (gap_q != '1)
			gap_q <= gap_q + 12'h001;
	end

	mrd_spacing_a: assert property (accept &&
		ctrl_q[`MRS_CTRL_STRICT] |-> gap_q >= 12'(TMRD_CYC - 1))
		else $error("second mrs taken inside spacing");
	mod_window_a: assert property (accept |=> mod_busy_q[*2])
		else $error("command window shorter than expected");
	idle_flag_a: assert property (cmd.mrs &&
		(!cmd.idle || !cmd.cke) &&
		ctrl_q[`MRS_CTRL_CHECK] |=> flag_q[`MRS_FLG_IDLE])
		else $error("mrs outside idle not flagged");
	odt_late_a: assert property (rtt_on_q && mod_busy_q &&
		cmd.odt && ctrl_q[`MRS_CTRL_CHECK] |=> flag_q[`MRS_FLG_ODT])
		else $error("odt high inside window not flagged");
	odt_free_a: assert property (!flag_q[`MRS_FLG_ODT] &&
		!rtt_on_q && !rtt_any(mr_q[1]) && !rtt_new
		|=> !flag_q[`MRS_FLG_ODT])
		else $error("odt flagged with termination off");
	upd_long_a: assert property (accept && exc |=>
		upd_busy && mrd_blk)
		else $error("exempt setting did not hold spacing");
	flag_sticky_a: assert property (flag_set[`MRS_FLG_CMD] |=>
		flag_q[`MRS_FLG_CMD])
		else $error("flag lost in clearing cycle");

	mrs_seen_c:  cover property (accept ##[1:20] accept);
	exc_seen_c:  cover property (accept && exc);
	odt_viol_c:  cover property ($rose(flag_q[`MRS_FLG_ODT]));
	rd_seen_c:   cover property (rvalid && rready);

endmodule

//--- test/mrs_ctl_model.sv
// controller model that drives the command slot of the mode bank
`timescale 1ns/1ns

module mrs_ctl_model
	import mrs_pkg::*;
#(
	parameter int GAP = 40
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// requests from the bench
	input  wire logic        go,
	input  wire logic [2:0]  sel,
	input  wire logic [13:0] addr,
	input  wire logic        rush,
	input  wire logic        busy,
	input  wire logic        oth,
	input  wire logic        odt,
	// command slot and completion
	output mrs_cmd_t         cmd,
	output logic             done
);
	int cnt; // cycles left before the next mrs may go

	// one mrs pulse per request; gap covers the long update too
	always @(posedge aclk) begin
		cmd.mrs   <= 1'b0;
		done      <= 1'b0;
		cmd.other <= oth;
		cmd.odt   <= odt;
		cmd.cke   <= 1'b1;
		cmd.idle  <= !busy;
		if (cnt != 0) cnt <= cnt - 1;
		if (!aresetn) begin
			cnt      <= 0;
			cmd.sel  <= 3'h0;
			cmd.addr <= 14'h0000;
		end else if (go && !done && (cnt == 0 || rush)) begin
			cmd.mrs  <= 1'b1;
			cmd.sel  <= sel;
			cmd.addr <= addr;
			cnt      <= GAP;
			done     <= 1'b1;
		end
	end
endmodule

//--- test/mrs_top_bench.sv
// self-checking bench for the mode register bank
`timescale 1ns/1ns
`include "mrs_consts.svh"

module mrs_top_bench
	import mrs_pkg::*;
;
	localparam int TMRD = 8;
	localparam int TMOD = 24;
	localparam int TUPD = 40;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        aclk, aresetn;
	logic        go, rush, busy, oth, odt, done;
	logic [2:0]  sel;
	logic [13:0] addr;
	mrs_cmd_t    cmd;
	logic [13:0] mr_out_q [`MRS_NUM_MR];
	logic        mrd_busy_q, mod_busy_q;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          n_mismatch, check_count;

	mrs_top #(.TMRD_CYC(TMRD), .TMOD_CYC(TMOD), .TUPD_CYC(TUPD)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .mr_out_q(mr_out_q),
		.mrd_busy_q(mrd_busy_q), .mod_busy_q(mod_busy_q),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	mrs_ctl_model #(.GAP(TUPD)) i_ctl (
		.aclk(aclk), .aresetn(aresetn), .go(go), .sel(sel), .addr(addr),
		.rush(rush), .busy(busy), .oth(oth), .odt(odt), .cmd(cmd),
		.done(done));

	// 100 ns clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a wait that ran out counts as a mismatch
	task hang;
		n_mismatch++;
		complete_run();
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// axi4-lite write, both channels offered together
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		awaddr <= a; wdata <= d; wstrb <= 4'hf;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (i == 50) hang();
		@(posedge aclk);
	endtask

	// axi4-lite read
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (i == 50) hang();
		@(posedge aclk);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
	endtask

	task clr;
		logic [1:0] r;
		wr(`MRS_OFS_FLAGS, 32'h0000000f, r);
	endtask

	// one mrs through the model; returns at the storing edge
	task mrs(input logic [2:0] s, input logic [13:0] v);
		int i;
		go <= 1'b1; sel <= s; addr <= v;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (done === 1'b1) break;
		end
		go <= 1'b0;
		if (i == 100) hang();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0);
		rdc(`MRS_OFS_CTRL, 32'h1);
		rdc(`MRS_OFS_FLAGS, 32'h0);
		rd(8'h30, d, r);
		chk(32'(r), 32'h2);
		$display("test reset done");
	endtask

	task t_load;
		logic [13:0] v;
		logic [1:0]  r;
		for (int i = 0; i < 7; i++) begin
			v = 14'h0aa0 ^ 14'(i);
			mrs(3'(i), v);
			@(posedge aclk);
			chk(32'(mr_out_q[i]), 32'(v));
			rdc(8'(4 * i), 32'(v));
		end
		mrs(3'h2, 14'h3fff);
		@(posedge aclk);
		chk(32'(mr_out_q[2]), 32'h3fff);
		wr(`MRS_OFS_MR0, 32'h00001234, r);
		chk(32'(r), 32'h2);
		rdc(`MRS_OFS_MR0, 32'h0aa0);
		rdc(`MRS_OFS_FLAGS, 32'h0);
		$display("test load done");
	endtask

	// busy windows measured from the storing edge
	task t_timing;
		int n1, n2;
		n1 = 0;
		n2 = 0;
		mrs(3'h0, 14'h0001);
		repeat (40) begin
			@(posedge aclk);
			if (mrd_busy_q === 1'b1) n1++;
			if (mod_busy_q === 1'b1) n2++;
		end
		chk(n1, TMRD - 1);
		chk(n2, TMOD - 1);
		$display("test timing done");
	endtask

	// mrs inside tmrd plus a command inside tmod
	task t_early;
		mrs(3'h0, 14'h0001);
		rush <= 1'b1;
		@(posedge aclk);
		mrs(3'h0, 14'h0002);
		rush <= 1'b0;
		oth <= 1'b1;
		@(posedge aclk);
		oth <= 1'b0;
		repeat (3) @(posedge aclk);
		rdc(`MRS_OFS_FLAGS, 32'h6);
		clr();
		rdc(`MRS_OFS_FLAGS, 32'h0);
		$display("test early done");
	endtask

	task t_idle;
		busy <= 1'b1;
		@(posedge aclk);
		mrs(3'h0, 14'h0003);
		busy <= 1'b0;
		repeat (3) @(posedge aclk);
		rdc(`MRS_OFS_FLAGS, 32'h1);
		clr();
		$display("test idle done");
	endtask

	// termination on: odt high in tmod flags; off both sides: free
	task t_odt;
		repeat (20) @(posedge aclk);
		odt <= 1'b1;
		mrs(3'h1, 14'h0100);
		odt <= 1'b0;
		repeat (3) @(posedge aclk);
		rdc(`MRS_OFS_FLAGS, 32'h8);
		clr();
		mrs(3'h1, 14'h0100);
		repeat (3) @(posedge aclk);
		odt <= 1'b1;
		@(posedge aclk);
		odt <= 1'b0;
		repeat (3) @(posedge aclk);
		rdc(`MRS_OFS_FLAGS, 32'h8);
		mrs(3'h1, 14'h0000);
		repeat (40) @(posedge aclk);
		clr();
		odt <= 1'b1;
		mrs(3'h1, 14'h0000);
		repeat (30) @(posedge aclk);
		odt <= 1'b0;
		rdc(`MRS_OFS_FLAGS, 32'h0);
		$display("test odt done");
	endtask

	// gear-down change keeps spacing busy past tmrd
	task t_long;
		logic [31:0] d;
		logic [1:0]  r;
		mrs(3'h3, 14'h0008);
		repeat (15) @(posedge aclk);
		rd(`MRS_OFS_STATUS, d, r);
		chk(d, 32'h00000003);
		mrs(3'h5, 14'h0ba5);
		repeat (15) @(posedge aclk);
		rd(`MRS_OFS_STATUS, d, r);
		chk(32'(d[0]), 32'h0);
		mrs(3'h5, 14'h0aa0);
		repeat (15) @(posedge aclk);
		rd(`MRS_OFS_STATUS, d, r);
		chk(32'(d[0]), 32'h1);
		$display("test long done");
	endtask

	// strict mode drops an early or non-idle mrs; check off flags none
	task t_strict;
		logic [1:0] r;
		wr(`MRS_OFS_CTRL, 32'h00000003, r);
		chk(32'(r), 32'h0);
		rdc(`MRS_OFS_CTRL, 32'h3);
		mrs(3'h2, 14'h0011);
		rush <= 1'b1;
		@(posedge aclk);
		mrs(3'h2, 14'h0022);
		rush <= 1'b0;
		busy <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(32'(mr_out_q[2]), 32'h0011);
		mrs(3'h2, 14'h0033);
		busy <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(32'(mr_out_q[2]), 32'h0011);
		rdc(`MRS_OFS_FLAGS, 32'h3);
		clr();
		wr(`MRS_OFS_CTRL, 32'h00000000, r);
		mrs(3'h2, 14'h0044);
		rush <= 1'b1;
		@(posedge aclk);
		mrs(3'h2, 14'h0055);
		rush <= 1'b0;
		@(posedge aclk);
		chk(32'(mr_out_q[2]), 32'h0055);
		rdc(`MRS_OFS_FLAGS, 32'h0);
		wr(`MRS_OFS_CTRL, 32'h00000001, r);
		$display("test strict done");
	endtask

	// reset in mid-run, while a long update is still pending
	task t_rst2;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`MRS_OFS_STATUS, 32'h0);
		for (int i = 0; i < 7; i++)
			chk(32'(mr_out_q[i]), 32'h0);
		rdc(`MRS_OFS_CTRL, 32'h1);
		rdc(`MRS_OFS_FLAGS, 32'h0);
		$display("test mid reset done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_mismatch = 0; check_count = 0;
		aresetn = 1'b0; go = 1'b0; rush = 1'b0; busy = 1'b0;
		oth = 1'b0; odt = 1'b0; sel = 3'h0; addr = 14'h0000;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
		wdata = 32'h0; wstrb = 4'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_load();
		t_timing();
		t_early();
		t_idle();
		t_strict();
		t_odt();
		t_long();
		t_rst2();
		complete_run();
	end
endmodule
